// [rtl/adc_cfg_consts.svh]
`ifndef ADC_CFG_CONSTS_SVH
`define ADC_CFG_CONSTS_SVH

// Register addresses within a page
`define ADC_CFG_PAGE_ADDR 8'h00
`define ADC_CFG_PROC_ADDR 8'h03
`define ADC_CFG_CLK_ADDR 8'h0d
`define ADC_CFG_CHAN_ADDR 8'h0e

// Page that holds the configuration registers
`define ADC_CFG_REG_PAGE 8'h00

// Reset values
`define ADC_CFG_PAGE_RST 8'h00
`define ADC_CFG_PROC_RST 8'h00
`define ADC_CFG_CLK_RST 8'h00
`define ADC_CFG_CHAN_RST 8'h00

// Writable bits of each register
`define ADC_CFG_PROC_WMASK 8'hef
`define ADC_CFG_CLK_WMASK 8'hdf
`define ADC_CFG_CHAN_WMASK 8'hf8

// Field positions
`define ADC_CFG_VOL_LOCK_BIT 1
`define ADC_CFG_BQ_EN_BIT 0
`define ADC_CFG_PROC_RO_BIT 4
`define ADC_CFG_PRI_OVR_BIT 7
`define ADC_CFG_SEC_OVR_BIT 6
`define ADC_CFG_CLK_RO_BIT 5
`define ADC_CFG_PRI_INT_FS_BIT 2
`define ADC_CFG_SEC_INT_FS_BIT 1
`define ADC_CFG_FORCE_CUST_BIT 7
`define ADC_CFG_CUST_MSB 6
`define ADC_CFG_CUST_LSB 3
`define ADC_CFG_CHAN_RO_MSB 2
`define ADC_CFG_CHAN_RO_LSB 0

`endif

// [rtl/adc_cfg_pkg.sv]
package adc_cfg_pkg;

    typedef logic [7:0] reg_byte_t;
    typedef logic [3:0] chan_mask_t;

    // Serial port one-hot select
    typedef enum logic [1:0]
    {
        PORT_PRIMARY = 2'b01,
        PORT_SECONDARY = 2'b10
    } port_sel_e;

endpackage

// [rtl/serial_role_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

module serial_role_ctrl
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic role_override,
    input wire logic role_select,
    input wire logic use_internal_fsync,
    output logic bclk_drive_r,
    output logic fsync_drive_r,
    output logic auto_detect_en_r,
    output logic internal_fsync_sel_r
);

    // Pin directions and auto-detect
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            bclk_drive_r <= 1'b0;
            fsync_drive_r <= 1'b0;
            auto_detect_en_r <= 1'b0;
        end
        else if (role_override)
        begin
            bclk_drive_r <= role_select;
            fsync_drive_r <= ~role_select;
            auto_detect_en_r <= 1'b0;
        end
        else
        begin
            bclk_drive_r <= role_select;
            fsync_drive_r <= role_select;
            auto_detect_en_r <= 1'b1;
        end
    end

    // Frame sync source in controller mode
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            internal_fsync_sel_r <= 1'b0;
        end
        else
        begin
            internal_fsync_sel_r <= role_select & use_internal_fsync;
        end
    end

    property p_ovr_sel_low;
        @(posedge clock) disable iff (sys_rst)
        (role_override && !role_select) |=> (!bclk_drive_r && fsync_drive_r);
    endproperty
    a_ovr_sel_low: assert property (p_ovr_sel_low) else $error("override select 0 wrong dirs");

    property p_ovr_sel_high;
        @(posedge clock) disable iff (sys_rst)
        (role_override && role_select) |=> (bclk_drive_r && !fsync_drive_r);
    endproperty
    a_ovr_sel_high: assert property (p_ovr_sel_high) else $error("override select 1 wrong dirs");

    property p_std_role;
        @(posedge clock) disable iff (sys_rst)
        !role_override ##1 1'b1 |-> (bclk_drive_r == $past(role_select))
            && (fsync_drive_r == $past(role_select)) && auto_detect_en_r;
    endproperty
    a_std_role: assert property (p_std_role) else $error("standard role mismatch");

    property p_ovr_no_auto;
        @(posedge clock) disable iff (sys_rst)
        $rose(role_override) |=> !auto_detect_en_r;
    endproperty
    a_ovr_no_auto: assert property (p_ovr_no_auto) else $error("auto-detect left on");

    // frame sync source tracks bit in controller mode
    property p_int_fsync;
        @(posedge clock) disable iff (sys_rst)
        role_select |=> (internal_fsync_sel_r == $past(use_internal_fsync));
    endproperty
    a_int_fsync: assert property (p_int_fsync) else $error("frame sync source wrong");

endmodule

`default_nettype wire

// [rtl/audio_adc_config_regs.sv]
// Summary of operation
// - Volume lock blocks volume changes while powered
// - Biquad enable permits coefficient changes while running
// - Primary role follows select; override kills auto-detect
// - Override select 0 bclk in, 1 bclk out
// - Secondary role follows select; override kills auto-detect
// - Secondary override select 1 bclk out, fsync in
// - Primary controller frame sync internal or external
// - Secondary controller frame sync internal or external
// - Force bit picks custom or automatic max channel
// - Custom mask bit n enables channel n+1
// - Addresses decode within page chosen at address zero
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_consts.svh"

module audio_adc_config_regs
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_r,
    input wire logic adc_powered_on,
    input wire logic digital_volume_change_req,
    output logic digital_volume_change_accept_r,
    input wire logic biquad_change_req,
    output logic biquad_change_accept_r,
    output logic volume_runtime_lock,
    output logic biquad_runtime_update_enable,
    input wire logic primary_role_select,
    input wire logic secondary_role_select,
    output logic [1:0] bclk_drive_r,
    output logic [1:0] fsync_drive_r,
    output logic [1:0] auto_detect_en_r,
    output logic [1:0] internal_fsync_sel_r,
    input wire logic [3:0] auto_max_channel_select,
    output logic [3:0] max_channel_enable_r
);

    adc_cfg_pkg::reg_byte_t page_r;
    adc_cfg_pkg::reg_byte_t proc_cfg_r;
    adc_cfg_pkg::reg_byte_t clk_cfg_r;
    adc_cfg_pkg::reg_byte_t chan_cfg_r;
    adc_cfg_pkg::reg_byte_t rdata_nxt;
    adc_cfg_pkg::chan_mask_t custom_mask;
    logic on_cfg_page;
    logic [1:0] override_vec;
    logic [1:0] select_vec;
    logic [1:0] int_fsync_vec;

    assign on_cfg_page = (page_r == `ADC_CFG_REG_PAGE);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            page_r <= `ADC_CFG_PAGE_RST;
        end
        else if (reg_wr_en && reg_addr == `ADC_CFG_PAGE_ADDR)
        begin
            page_r <= reg_wdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            proc_cfg_r <= `ADC_CFG_PROC_RST;
        end
        else if (reg_wr_en && on_cfg_page && reg_addr == `ADC_CFG_PROC_ADDR)
        begin
            proc_cfg_r <= reg_wdata & `ADC_CFG_PROC_WMASK;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            clk_cfg_r <= `ADC_CFG_CLK_RST;
        end
        else if (reg_wr_en && on_cfg_page && reg_addr == `ADC_CFG_CLK_ADDR)
        begin
            clk_cfg_r <= reg_wdata & `ADC_CFG_CLK_WMASK;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            chan_cfg_r <= `ADC_CFG_CHAN_RST;
        end
        else if (reg_wr_en && on_cfg_page && reg_addr == `ADC_CFG_CHAN_ADDR)
        begin
            chan_cfg_r <= reg_wdata & `ADC_CFG_CHAN_WMASK;
        end
    end

    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_addr == `ADC_CFG_PAGE_ADDR)
        begin
            rdata_nxt = page_r;
        end
        else if (on_cfg_page)
        begin
            case (reg_addr)
                `ADC_CFG_PROC_ADDR: rdata_nxt = proc_cfg_r;
                `ADC_CFG_CLK_ADDR: rdata_nxt = clk_cfg_r;
                `ADC_CFG_CHAN_ADDR: rdata_nxt = chan_cfg_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            reg_rdata_r <= 8'h00;
        end
        else if (reg_rd_en)
        begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    assign volume_runtime_lock = proc_cfg_r[`ADC_CFG_VOL_LOCK_BIT];
    assign biquad_runtime_update_enable = proc_cfg_r[`ADC_CFG_BQ_EN_BIT];

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            digital_volume_change_accept_r <= 1'b0;
        end
        else
        begin
            digital_volume_change_accept_r <= digital_volume_change_req
                && !(adc_powered_on && proc_cfg_r[`ADC_CFG_VOL_LOCK_BIT]);
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            biquad_change_accept_r <= 1'b0;
        end
        else
        begin
            biquad_change_accept_r <= biquad_change_req
                && (!adc_powered_on || proc_cfg_r[`ADC_CFG_BQ_EN_BIT]);
        end
    end

    // Index 0 primary, index 1 secondary
    assign override_vec = {clk_cfg_r[`ADC_CFG_SEC_OVR_BIT], clk_cfg_r[`ADC_CFG_PRI_OVR_BIT]};
    assign select_vec = {secondary_role_select, primary_role_select};
    assign int_fsync_vec = {clk_cfg_r[`ADC_CFG_SEC_INT_FS_BIT],
                            clk_cfg_r[`ADC_CFG_PRI_INT_FS_BIT]};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_port
            serial_role_ctrl u_role
            (
                .clock(clock),
                .sys_rst(sys_rst),
                .role_override(override_vec[gi]),
                .role_select(select_vec[gi]),
                .use_internal_fsync(int_fsync_vec[gi]),
                .bclk_drive_r(bclk_drive_r[gi]),
                .fsync_drive_r(fsync_drive_r[gi]),
                .auto_detect_en_r(auto_detect_en_r[gi]),
                .internal_fsync_sel_r(internal_fsync_sel_r[gi])
            );
        end
    endgenerate

    // mask bit n is channel n+1
    assign custom_mask = chan_cfg_r[`ADC_CFG_CUST_MSB:`ADC_CFG_CUST_LSB];

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            max_channel_enable_r <= 4'h0;
        end
        else if (chan_cfg_r[`ADC_CFG_FORCE_CUST_BIT])
        begin
            max_channel_enable_r <= custom_mask;
        end
        else
        begin
            max_channel_enable_r <= auto_max_channel_select;
        end
    end

    property p_vol_locked;
        @(posedge clock) disable iff (sys_rst)
        (digital_volume_change_req && adc_powered_on && volume_runtime_lock)
            |=> !digital_volume_change_accept_r;
    endproperty
    a_vol_locked: assert property (p_vol_locked) else $error("locked volume accepted");

    property p_vol_free;
        @(posedge clock) disable iff (sys_rst)
        (digital_volume_change_req && !volume_runtime_lock) |=> digital_volume_change_accept_r;
    endproperty
    a_vol_free: assert property (p_vol_free) else $error("unlocked volume refused");

    // biquad change tracks enable while running
    property p_bq_run;
        @(posedge clock) disable iff (sys_rst)
        (biquad_change_req && adc_powered_on)
            |=> (biquad_change_accept_r == $past(biquad_runtime_update_enable));
    endproperty
    a_bq_run: assert property (p_bq_run) else $error("biquad gate wrong");

    property p_max_ch;
        @(posedge clock) disable iff (sys_rst)
        1'b1 ##1 1'b1 |-> max_channel_enable_r == ($past(chan_cfg_r[`ADC_CFG_FORCE_CUST_BIT])
            ? $past(custom_mask) : $past(auto_max_channel_select));
    endproperty
    a_max_ch: assert property (p_max_ch) else $error("max channel source wrong");

    // custom mask write lands in channel field
    property p_cust_write;
        @(posedge clock) disable iff (sys_rst)
        (reg_wr_en && on_cfg_page && reg_addr == `ADC_CFG_CHAN_ADDR)
            |=> custom_mask == $past(reg_wdata[`ADC_CFG_CUST_MSB:`ADC_CFG_CUST_LSB]);
    endproperty
    a_cust_write: assert property (p_cust_write) else $error("custom mask not stored");

    property p_ro_zero;
        @(posedge clock) disable iff (sys_rst)
        reg_wr_en |=> !proc_cfg_r[`ADC_CFG_PROC_RO_BIT] && !clk_cfg_r[`ADC_CFG_CLK_RO_BIT]
            && chan_cfg_r[`ADC_CFG_CHAN_RO_MSB:`ADC_CFG_CHAN_RO_LSB] == 3'h0;
    endproperty
    a_ro_zero: assert property (p_ro_zero) else $error("read-only bit set");

    property p_page_block;
        @(posedge clock) disable iff (sys_rst)
        (reg_wr_en && !on_cfg_page && reg_addr != `ADC_CFG_PAGE_ADDR)
            |=> $stable(proc_cfg_r) && $stable(clk_cfg_r) && $stable(chan_cfg_r);
    endproperty
    a_page_block: assert property (p_page_block) else $error("write leaked across page");

    property p_page_read;
        @(posedge clock) disable iff (sys_rst)
        (reg_rd_en && !on_cfg_page && reg_addr != `ADC_CFG_PAGE_ADDR) |=> reg_rdata_r == 8'h00;
    endproperty
    a_page_read: assert property (p_page_read) else $error("off-page read not zero");

    property p_vol_idle;
        @(posedge clock) disable iff (sys_rst)
        !digital_volume_change_req |=> !digital_volume_change_accept_r;
    endproperty
    a_vol_idle: assert property (p_vol_idle) else $error("volume accept without request");

    property p_bq_idle;
        @(posedge clock) disable iff (sys_rst)
        (biquad_change_req && !adc_powered_on) |=> biquad_change_accept_r;
    endproperty
    a_bq_idle: assert property (p_bq_idle) else $error("idle biquad change refused");

    property p_page_write;
        @(posedge clock) disable iff (sys_rst)
        (reg_wr_en && reg_addr == `ADC_CFG_PAGE_ADDR) |=> page_r == $past(reg_wdata);
    endproperty
    a_page_write: assert property (p_page_write) else $error("page write lost");

    property p_rd_hold;
        @(posedge clock) disable iff (sys_rst)
        !reg_rd_en |=> $stable(reg_rdata_r);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");

endmodule

`default_nettype wire

// [test/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_consts.svh"

module host_model
(
    input wire logic clock,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r
);
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    function automatic logic [7:0] fld(input logic [7:0] a);
        case (a)
            `ADC_CFG_PROC_ADDR: return 8'h03;
            `ADC_CFG_CLK_ADDR: return 8'hc6;
            `ADC_CFG_CHAN_ADDR: return 8'hf8;
            default: return 8'hff;
        endcase
    endfunction

    // Raw writes reach reserved bits on purpose
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic raw);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = raw ? d : (d & fld(a));
        reg_wr_en = 1'b1;
        @(posedge clock);
        @(negedge clock);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge clock);
        @(negedge clock);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        @(negedge clock);
        d = reg_rdata_r;
    endtask
endmodule

`default_nettype wire

// [test/audio_adc_config_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module audio_adc_config_regs_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic wr_en, rd_en, pw = 1'b0, vreq = 1'b0, breq = 1'b0, psel = 1'b0, ssel = 1'b0;
    logic [7:0] addr, wdata, rdata, d;
    logic vacc, bacc, vlock, bqen;
    logic [1:0] bclk, fsy, adet, ifs;
    logic [3:0] auto_ch = 4'h0, max_ch;
    int err_total = 0;
    int checks = 0;
    logic [7:0] adr [3] = '{`ADC_CFG_PROC_ADDR, `ADC_CFG_CLK_ADDR, `ADC_CFG_CHAN_ADDR};
    logic [7:0] msk [3] = '{`ADC_CFG_PROC_WMASK, `ADC_CFG_CLK_WMASK, `ADC_CFG_CHAN_WMASK};

    host_model host (.clock(clock), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata_r(rdata));

    audio_adc_config_regs uut (.clock(clock), .sys_rst(sys_rst), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_r(rdata),
        .adc_powered_on(pw), .digital_volume_change_req(vreq),
        .digital_volume_change_accept_r(vacc), .biquad_change_req(breq),
        .biquad_change_accept_r(bacc), .volume_runtime_lock(vlock),
        .biquad_runtime_update_enable(bqen), .primary_role_select(psel),
        .secondary_role_select(ssel), .bclk_drive_r(bclk), .fsync_drive_r(fsy),
        .auto_detect_en_r(adet), .internal_fsync_sel_r(ifs),
        .auto_max_channel_select(auto_ch), .max_channel_enable_r(max_ch));

    initial
    begin
        forever #50 clock = ~clock;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic t_reset();
        @(negedge clock);
        sys_rst = 1'b1;
        auto_ch = 4'h6;
        repeat (5) @(negedge clock);
        sys_rst = 1'b0;
        repeat (2) @(negedge clock);
        host.rd(`ADC_CFG_PAGE_ADDR, d);
        `CHK(d, 8'h00)
        for (int i = 0; i < 3; i++)
        begin
            host.rd(adr[i], d);
            `CHK(d, 8'h00)
        end
        `CHK({vlock, bqen, adet, max_ch}, 8'h36)
    endtask

    task automatic t_masks();
        for (int i = 0; i < 3; i++)
        begin
            host.wr(adr[i], 8'hff, 1'b1);
            host.rd(adr[i], d);
            `CHK(d, msk[i])
        end
        `CHK({vlock, bqen}, 2'b11)
        for (int i = 0; i < 3; i++)
        begin
            host.wr(adr[i], 8'h00, 1'b1);
            host.rd(adr[i], d);
            `CHK(d, 8'h00)
        end
    endtask

    task automatic t_page();
        host.wr(`ADC_CFG_PAGE_ADDR, 8'h01, 1'b0);
        host.rd(`ADC_CFG_PAGE_ADDR, d);
        `CHK(d, 8'h01)
        host.wr(`ADC_CFG_PROC_ADDR, 8'h03, 1'b0);
        host.rd(`ADC_CFG_PROC_ADDR, d);
        `CHK(d, 8'h00)
        host.wr(`ADC_CFG_PAGE_ADDR, 8'h00, 1'b0);
        host.rd(`ADC_CFG_PROC_ADDR, d);
        `CHK(d, 8'h00)
        `CHK(vlock, 1'b0)
        host.rd(8'h05, d);
        `CHK(d, 8'h00)
    endtask

    task automatic t_proc();
        for (int i = 0; i < 8; i++)
        begin
            host.wr(`ADC_CFG_PROC_ADDR, {6'h00, i[1:0]}, 1'b0);
            pw = i[2];
            vreq = 1'b1;
            breq = 1'b1;
            @(negedge clock);
            `CHK(vacc, !(i[2] && i[1]))
            `CHK(bacc, !i[2] || i[0])
            vreq = 1'b0;
            breq = 1'b0;
            @(negedge clock);
            `CHK({vacc, bacc}, 2'b00)
        end
        pw = 1'b0;
    endtask

    task automatic t_role();
        logic [5:0] v;
        for (int i = 0; i < 64; i++)
        begin
            v = i[5:0];
            host.wr(`ADC_CFG_CLK_ADDR, {v[0], v[1], 3'h0, v[2], v[3], 1'b0}, 1'b0);
            psel = v[4];
            ssel = v[5];
            repeat (2) @(negedge clock);
            `CHK(bclk, {v[5], v[4]})
            `CHK(fsy, {v[5] ^ v[1], v[4] ^ v[0]})
            `CHK(adet, {~v[1], ~v[0]})
            `CHK(ifs, {v[5] & v[3], v[4] & v[2]})
        end
    endtask

    task automatic t_chan();
        auto_ch = 4'ha;
        host.wr(`ADC_CFG_CHAN_ADDR, {1'b0, 4'h5, 3'h0}, 1'b0);
        repeat (2) @(negedge clock);
        `CHK(max_ch, 4'ha)
        for (int b = 0; b < 4; b++)
        begin
            host.wr(`ADC_CFG_CHAN_ADDR, {1'b1, 4'h1 << b, 3'h0}, 1'b0);
            auto_ch = 4'hf;
            repeat (2) @(negedge clock);
            `CHK(max_ch, 4'h1 << b)
        end
    endtask

    initial
    begin
        t_reset();
        t_masks();
        t_page();
        t_proc();
        t_role();
        t_chan();
        host.wr(`ADC_CFG_PROC_ADDR, 8'h03, 1'b0);
        host.wr(`ADC_CFG_PAGE_ADDR, 8'h02, 1'b0);
        t_reset();
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        conclude();
    end
endmodule

`default_nettype wire
